// ===== asr_ctrl.sv
`timescale 1ns/1ps
`include "asr_consts.svh"
// Operation
// - the write strobe stays high throughout every read cycle.
// - for a read the address is stable no later than the falling edge of select.
// - a write starts with all inputs valid and ends at the first strobe to rise.
// - data and address are timed to the rising edge that ends the write.
// - a write may be timed by select, output enable at either level; the code times every write by the write strobe instead.
// - a write may be timed by the write strobe with output enable held high.
// - with output enable low in a strobe-timed write the longer pulse is used.
module asr_ctrl
  import asr_pkg::*;
#(
  parameter int AW = `ASR_ADDR_W,
  parameter int DW = `ASR_DATA_W
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic i_oe_low_wr,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic o_ready,
  output logic o_rvalid,
  output logic [DW-1:0] o_rdata,
  output logic [AW-1:0] o_word_address,
  output logic o_sel_n,
  output logic o_oe_n,
  output logic o_we_n,
  input wire logic [DW-1:0] i_data_bus,
  output logic [DW-1:0] o_data_bus,
  output logic o_data_bus_oe
);
  localparam int CW = `ASR_CNT_W;
  localparam logic [CW-1:0] RD_CYC = CW'(`ASR_CYC(`ASR_T_RC_PS));
  localparam logic [CW-1:0] HZ_CYC = CW'(`ASR_CYC(`ASR_T_HZ_PS));
  localparam logic [CW-1:0] PW1_CYC = CW'(`ASR_CYC(`ASR_T_PWE1_PS));
  localparam logic [CW-1:0] PW2_CYC = CW'(`ASR_CYC(`ASR_T_PWE2_PS));
  localparam logic [CW-1:0] SD_CYC = CW'(`ASR_CYC(`ASR_T_SD_PS));

  initial begin
    if (AW != `ASR_ADDR_W || DW != `ASR_DATA_W)
      $error("asr_ctrl: memory is 18 by 8 only");
  end

  typedef struct packed {
    asr_state_t st;
    logic oe_low;
    logic ready;
    logic rvalid;
    logic [DW-1:0] rdata;
    logic [AW-1:0] addr;
    logic sel_n;
    logic oe_n;
    logic we_n;
    logic [DW-1:0] dout;
    logic dout_oe;
  } asr_regs_t;

  asr_regs_t r_ff, nxt_r;
  logic tmr_load;
  logic [CW-1:0] tmr_count;
  logic tmr_zero;

  asr_timer #(.CW(CW)) u_timer (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_zero(tmr_zero)
  );

  ////////////////////////////////////////////////////////////////
  // sequencing of one access at a time
  always_comb begin
    nxt_r = r_ff;
    nxt_r.rvalid = 1'b0;
    tmr_load = 1'b0;
    tmr_count = '0;
    unique case (r_ff.st)
      ASR_IDLE: begin
        nxt_r.sel_n = 1'b1; // idle: deselected, standby
        nxt_r.we_n = 1'b1;
        nxt_r.oe_n = 1'b1;
        nxt_r.dout_oe = 1'b0;
        if (i_req) begin
          nxt_r.ready = 1'b0;
          nxt_r.addr = i_addr; // address set with select fall
          nxt_r.sel_n = 1'b0;
          if (i_we) begin
            // strobe timed write: select falls now, strobe next
            nxt_r.oe_low = i_oe_low_wr;
            nxt_r.oe_n = !i_oe_low_wr;
            nxt_r.dout = i_wdata;
            nxt_r.st = ASR_WR_FLOAT;
          end else begin
            nxt_r.oe_n = 1'b0; // we high, bus released
            tmr_load = 1'b1;
            tmr_count = RD_CYC;
            nxt_r.st = ASR_RD_SEL;
          end
        end
      end
      ASR_RD_SEL: begin
        // wait out access time before sampling
        if (tmr_zero) begin
          nxt_r.st = ASR_RD_CAP;
        end
      end
      ASR_RD_CAP: begin
        nxt_r.rdata = i_data_bus;
        nxt_r.rvalid = 1'b1;
        nxt_r.sel_n = 1'b1;
        nxt_r.oe_n = 1'b1;
        nxt_r.st = ASR_RECOVER;
      end
      ASR_WR_FLOAT: begin
        // strobe falls with address and select stable; data is driven only later
        nxt_r.we_n = 1'b0;
        tmr_load = 1'b1;
        tmr_count = HZ_CYC; // memory floats within this
        nxt_r.st = ASR_WR_PULSE;
      end
      ASR_WR_PULSE: begin
        // drive only after memory has floated
        if (tmr_zero && !r_ff.dout_oe) begin
          nxt_r.dout_oe = 1'b1;
          tmr_load = 1'b1;
          // longer pulse when output enable is low
          tmr_count = r_ff.oe_low ? PW2_CYC : PW1_CYC;
          if (SD_CYC > tmr_count) tmr_count = SD_CYC;
        end else if (tmr_zero && r_ff.dout_oe) begin
          nxt_r.we_n = 1'b1; // strobe rise ends write
          // memory would drive again into held data otherwise
          nxt_r.oe_n = 1'b1;
          nxt_r.st = ASR_WR_HOLD;
        end
      end
      ASR_WR_HOLD: begin
        // zero hold: release data and select one cycle later
        nxt_r.sel_n = 1'b1;
        nxt_r.oe_n = 1'b1;
        nxt_r.dout_oe = 1'b0;
        nxt_r.st = ASR_RECOVER;
      end
      ASR_RECOVER: begin
        nxt_r.ready = 1'b1;
        nxt_r.st = ASR_IDLE;
      end
      default: begin
        nxt_r.st = ASR_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // single state register
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_ff <= '{st: ASR_IDLE, oe_low: 1'b0, ready: 1'b1, rvalid: 1'b0,
                rdata: '0, addr: '0, sel_n: 1'b1, oe_n: 1'b1,
                we_n: 1'b1, dout: '0, dout_oe: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign o_ready = r_ff.ready;
  assign o_rvalid = r_ff.rvalid;
  assign o_rdata = r_ff.rdata;
  assign o_word_address = r_ff.addr;
  assign o_sel_n = r_ff.sel_n;
  assign o_oe_n = r_ff.oe_n;
  assign o_we_n = r_ff.we_n;
  assign o_data_bus = r_ff.dout;
  assign o_data_bus_oe = r_ff.dout_oe;

  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_wr_start;
    $fell(o_we_n) && !o_sel_n;
  endsequence

  a_read_we_high: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (!o_sel_n && !o_oe_n && !o_data_bus_oe) |-> o_we_n || r_ff.oe_low)
    else $error("write strobe low during read");
  a_no_contention: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_data_bus_oe |-> !o_we_n || o_oe_n)
    else $error("data driven outside write");
  a_addr_stable: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !o_sel_n && !$past(o_sel_n) |-> $stable(o_word_address))
    else $error("address moved while selected");
  a_wr_pulse_len: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_wr_start |-> !o_we_n [*2])
    else $error("write pulse too short");
  a_data_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(o_we_n) |-> o_data_bus_oe && $stable(o_data_bus))
    else $error("data not held at write end");
  a_write_sel: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !o_we_n |-> !o_sel_n)
    else $error("strobe low while deselected");
  a_write_ends: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_wr_start |-> ##[1:10] o_we_n)
    else $error("write never ended");
  a_idle_deselect: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    r_ff.st == ASR_IDLE && o_ready |-> o_sel_n)
    else $error("selected while idle");
  a_read_answer: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (o_ready && i_req && !i_we) |-> ##[2:4] o_rvalid)
    else $error("read answer late");
endmodule

// ===== asr_consts.svh
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
`define ASR_CLK_PS 20000
`define ASR_ADDR_W 18
`define ASR_DATA_W 8
// times in picoseconds, fastest grade
`define ASR_T_RC_PS 8000
`define ASR_T_PWE1_PS 5000
`define ASR_T_PWE2_PS 6500
`define ASR_T_SD_PS 4000
`define ASR_T_HZ_PS 3000
// least times round up, at least one cycle
`define ASR_CYC(t) (((t) + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_CNT_W 4
`endif

// ===== asr_pkg.sv
package asr_pkg;
  typedef enum logic [2:0] {
    ASR_IDLE,
    ASR_RD_SEL,
    ASR_RD_CAP,
    ASR_WR_FLOAT,
    ASR_WR_PULSE,
    ASR_WR_HOLD,
    ASR_RECOVER
  } asr_state_t;
endpackage

// ===== asr_timer.sv
`timescale 1ns/1ps
`include "asr_consts.svh"
// down-counter: load a cycle count, flags zero
module asr_timer
  import asr_pkg::*;
#(
  parameter int CW = `ASR_CNT_W
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_load,
  input wire logic [CW-1:0] i_count,
  output logic o_zero
);
  typedef struct packed {
    logic [CW-1:0] cnt;
  } asr_tmr_t;

  asr_tmr_t t_ff, nxt_t;

  initial begin
    if (CW < 1)
      $error("asr_timer: counter needs at least one bit");
  end

  // reload wins over counting; stops at zero
  always_comb begin
    nxt_t = t_ff;
    if (i_load) begin
      nxt_t.cnt = i_count;
    end else if (t_ff.cnt != '0) begin
      nxt_t.cnt = t_ff.cnt - 1'b1;
    end
  end

  // single counter register
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      t_ff <= '0;
    end else begin
      t_ff <= nxt_t;
    end
  end

  assign o_zero = (t_ff.cnt == '0);
endmodule

// ===== asr_sram_model.sv
`timescale 1ns/1ps
// behavioural memory on the far side of the port
module asr_sram_model (
  input wire logic i_sel_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [17:0] i_word_address,
  input wire logic [7:0] i_data_bus,
  output logic [7:0] o_data_bus,
  output logic o_drive
);
  logic [7:0] mem [logic [17:0]];
  logic [7:0] last = 8'h00;
  logic wr_act;
  // only a real low window may store; the fall from unknown at reset must not
  logic armed = 1'b0;
  // pins driven only while read-selected
  assign o_drive = !i_sel_n && !i_oe_n && i_we_n;
  assign wr_act = !i_sel_n && !i_we_n;
  // released pins show the inverse, so a stale value cannot pass
  always @* begin
    if (o_drive) begin
      last = mem.exists(i_word_address) ? mem[i_word_address] : 8'hA5;
      o_data_bus = last;
    end else
      o_data_bus = ~last;
  end
  // latched at whichever strobe rises first
  always @(posedge wr_act)
    armed = 1'b1;
  always @(negedge wr_act) begin
    if (armed) begin
      mem[i_word_address] = i_data_bus;
      armed = 1'b0;
    end
  end
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rstn = 0, req = 0, we = 0, oel = 0, reading = 0;
  logic [17:0] addr = '0, a, pwa;
  logic [7:0] wd = '0, d;
  logic rdy, rv, sel_n, oe_n, we_n, doe, mdrv, psel;
  logic [7:0] rdata, dout, mdata, bus;
  logic [17:0] wa;
  logic [7:0] shadow [logic [17:0]];
  integer n_errors = 0, total_checks = 0, seed = 32'hEDC0, cyc = 0;
  always #10 clk = ~clk;
  // wire level from both drivers
  assign bus = doe ? dout : mdata;
  asr_ctrl asr_ctrl_inst (.i_mclk(clk), .i_resetn(rstn), .i_req(req),
    .i_we(we), .i_oe_low_wr(oel), .i_addr(addr), .i_wdata(wd),
    .o_ready(rdy), .o_rvalid(rv), .o_rdata(rdata), .o_word_address(wa),
    .o_sel_n(sel_n), .o_oe_n(oe_n), .o_we_n(we_n), .i_data_bus(bus),
    .o_data_bus(dout), .o_data_bus_oe(doe));
  asr_sram_model asr_sram_model_inst (.i_sel_n(sel_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_word_address(wa), .i_data_bus(bus),
    .o_data_bus(mdata), .o_drive(mdrv));
  //////////////////////////////////////////////////////////////////////
  task automatic check_data(string what, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_flag(string what, logic e, logic g);
    check_data(what, {7'h00, e}, {7'h00, g});
  endtask
  // unwritten words read as the model's fill value
  function automatic logic [7:0] exp_byte(logic [17:0] x);
    return shadow.exists(x) ? shadow[x] : 8'hA5;
  endfunction
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // one access; a bogus request while busy must be ignored
  task automatic access(logic w, logic ol, logic [17:0] x, logic [7:0] v);
    int n;
    logic [7:0] e;
    e = exp_byte(x);
    @(posedge clk);
    #1 req = 1; we = w; oel = ol; addr = x; wd = v; reading = !w;
    @(negedge clk);
    while (rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    #1 req = 0;
    if (w) shadow[x] = v;
    check_flag("output enable", w ? !ol : 1'b0, oe_n);
    @(posedge clk);
    #1 req = 1; addr = ~x; wd = ~v;
    @(posedge clk);
    #1 req = 0;
    n = 0;
    if (!w) begin
      while (rv !== 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      check_flag("read valid", 1'b1, rv);
      check_data("read data", e, rdata);
    end
    while (rdy !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check_flag("select idle", 1'b1, sel_n);
    reading = 0;
    $display("done %s %h", w ? "write" : "read", x);
  endtask
  //////////////////////////////////////////////////////////////////////
  // wire watch on settled values, plus the hang limit
  always @(negedge clk) begin
    psel <= sel_n;
    pwa <= wa;
    if (rstn) begin
      cyc++;
      check_flag("one bus driver", 1'b0, doe & mdrv);
      if (reading) check_flag("strobe in read", 1'b1, we_n);
      if (!sel_n && !psel) check_flag("addr held", 1'b1, wa === pwa);
      if (cyc > 3000) begin
        n_errors++;
        give_verdict();
      end
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rstn = 1;
    // corner words and both write kinds
    access(1, 0, 18'h00000, 8'h00);
    access(1, 1, 18'h3FFFF, 8'hFF);
    access(0, 0, 18'h00000, 8'h00);
    access(0, 0, 18'h3FFFF, 8'hFF);
    // random traffic read back, poked word must stay unwritten
    repeat (30) begin
      a = 18'($random(seed));
      d = 8'($random(seed));
      access(1, d[0], a, d);
      access(0, 0, a, 8'h00);
      access(0, 0, ~a, 8'h00);
    end
    give_verdict();
  end
endmodule
